// ---- sefe_pkg.sv ----
// Shared constants and types for the serial EEPROM front end
package sefe_pkg;

    // Array organisation
    localparam int unsigned ARRAY_WORDS = 32768;
    localparam int unsigned ID_WORDS    = 64;
    localparam int unsigned PAGE_BYTES  = 64;
    localparam int unsigned MEM_AW      = 16;
    localparam int unsigned MEM_DEPTH   = ARRAY_WORDS + ID_WORDS;

    // Instruction codes
    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_RDSR  = 8'h05;
    localparam logic [7:0] OP_WRSR  = 8'h01;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_RDID  = 8'h83;
    localparam logic [7:0] OP_WRID  = 8'h82;

    // Address bit that turns an identification page write into a lock
    localparam int unsigned LOCK_ADDR_BIT = 10;

    // Lower bounds of the protected regions
    localparam logic [14:0] PROT_QUARTER_BASE = 15'h6000;
    localparam logic [14:0] PROT_HALF_BASE    = 15'h4000;

    // Byte pointer width across the link crossing
    localparam int unsigned PTR_W = 4;

    // Reset values of the block-protect bits
    localparam logic [1:0] PROT_SIZE_RST = 2'h0;

    // Internal write cycle time
    localparam int unsigned T_WRITE_MS       = 5;
    localparam int unsigned CLK_FREQ_KHZ     = 100000;
    localparam int unsigned WRITE_CYCLES_DEF = T_WRITE_MS * CLK_FREQ_KHZ;

    // Status byte layout, low nibble; upper bits read as zero
    typedef struct packed {
        logic prot_size_hi;
        logic prot_size_lo;
        logic write_enable_latch;
        logic write_in_progress;
    } sefe_status_s;

    // Byte sequencer states
    typedef enum logic [2:0] {
        S_OPCODE,
        S_ADDR_HI,
        S_ADDR_LO,
        S_DATA,
        S_STAT,
        S_WRSR,
        S_SKIP
    } sefe_state_e;

endpackage

// ---- sefe_mem.sv ----
// Byte memory with one write port and a registered read port
module sefe_mem #(
    parameter int unsigned DW    = 8,
    parameter int unsigned DEPTH = 32832,
    parameter int unsigned AW    = 16
) (
    input  wire logic          clk_i,
    input  wire logic          en_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);

    logic [DW-1:0] mem_q [DEPTH];

    // Write port; out of range addresses are dropped
    always_ff @(posedge clk_i) begin
        if (en_i && we_i && (32'(waddr_i) < DEPTH)) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Read data always comes from a register
    always_ff @(posedge clk_i) begin
        if (en_i) begin
            rdata_o <= (32'(raddr_i) < DEPTH) ? mem_q[raddr_i] : '0;
        end
    end

endmodule

// ---- sefe_top.sv ----
// Serial EEPROM front end: link-clock shifter, system-clock sequencer, array
//////////////////////////////////////////////////////////////////////////////
module sefe_top #(
    parameter int unsigned WRITE_CYCLES = sefe_pkg::WRITE_CYCLES_DEF,
    parameter bit          HAS_ID_PAGE  = 1'b1
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic spi_sck_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_mosi_i,
    input  wire logic spi_hold_n_i,
    input  wire logic spi_wp_n_i,
    output logic      spi_miso_o,
    output logic      spi_miso_oe_n_o,
    output logic      active_o,
    output logic      standby_o,
    output logic      paused_o,
    output sefe_pkg::sefe_status_s status_o
);
    import sefe_pkg::*;

    localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

    //////////////////////////////////////////////////////////////////////////
    // Link clock domain. Chip select high clears it at once; hold and data
    // are timed against the serial clock, so sampling them on its edges is
    // synchronous and needs no extra stages.

    logic [2:0]       bit_cnt_q;
    logic [6:0]       rx_sh_q;
    logic [7:0]       rx_byte_q;
    logic [PTR_W-1:0] wr_bin_q;
    logic [PTR_W-1:0] wr_gray_q;
    logic [PTR_W-1:0] wr_nxt;
    logic [7:0]       tx_sh_q;
    logic [7:0]       tx_byte_q;

    assign wr_nxt = wr_bin_q + 1'b1;

    // Receive shifter on rising edges
    always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            bit_cnt_q <= 3'h0;
            rx_sh_q   <= 7'h00;
            rx_byte_q <= 8'h00;
            wr_bin_q  <= '0;
            wr_gray_q <= '0;
        end else if (spi_hold_n_i) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q   <= {rx_sh_q[5:0], spi_mosi_i};
            if (bit_cnt_q == 3'h7) begin
                rx_byte_q <= {rx_sh_q, spi_mosi_i};
                wr_bin_q  <= wr_nxt;
                wr_gray_q <= wr_nxt ^ (wr_nxt >> 1);
            end
        end
    end

    // Transmit shifter on falling edges; a new byte loads at each boundary
    always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) begin
            tx_sh_q    <= 8'h00;
            spi_miso_o <= 1'b0;
        end else if (spi_hold_n_i) begin
            if (bit_cnt_q == 3'h0) begin
                spi_miso_o <= tx_byte_q[7];
                tx_sh_q    <= {tx_byte_q[6:0], 1'b0};
            end else begin
                spi_miso_o <= tx_sh_q[7];
                tx_sh_q    <= {tx_sh_q[6:0], 1'b0};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // System clock domain: pin and pointer synchronisers

    logic             cs_s1_q;
    logic             cs_s2_q;
    logic             cs_d_q;
    logic             hold_s1_q;
    logic             hold_s2_q;
    logic             wp_s1_q;
    logic             wp_s2_q;
    logic [PTR_W-1:0] ptr_s1_q;
    logic [PTR_W-1:0] ptr_s2_q;
    logic [PTR_W-1:0] ptr_s3_q;

    // Third pointer stage lets the select rise be seen before the pointer
    // clear, so a frame end never looks like a fresh byte
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            cs_d_q    <= 1'b1;
            hold_s1_q <= 1'b1;
            hold_s2_q <= 1'b1;
            wp_s1_q   <= 1'b1;
            wp_s2_q   <= 1'b1;
            ptr_s1_q  <= '0;
            ptr_s2_q  <= '0;
            ptr_s3_q  <= '0;
        end else if (ce_i) begin
            cs_s1_q   <= spi_cs_n_i;
            cs_s2_q   <= cs_s1_q;
            cs_d_q    <= cs_s2_q;
            hold_s1_q <= spi_hold_n_i;
            hold_s2_q <= hold_s1_q;
            wp_s1_q   <= spi_wp_n_i;
            wp_s2_q   <= wp_s1_q;
            ptr_s1_q  <= wr_gray_q;
            ptr_s2_q  <= ptr_s1_q;
            ptr_s3_q  <= ptr_s2_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Frame tracking and byte hand-over

    logic             cs_fall;
    logic             cs_rise;
    logic             seen_high_q;
    logic [1:0]       sync_fill_q;
    logic             frame_ok_q;
    logic [PTR_W-1:0] rd_bin_q;
    logic             byte_new;
    logic             byte_take;

    assign cs_fall   = cs_d_q & ~cs_s2_q;
    assign cs_rise   = ~cs_d_q & cs_s2_q;
    assign byte_new  = ~cs_s2_q && (ptr_s3_q != (rd_bin_q ^ (rd_bin_q >> 1)));
    assign byte_take = byte_new & frame_ok_q;

    // frame counts only after a seen high; the fill bits stop the
    // synchroniser's reset value from passing for a real high pin
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            seen_high_q <= 1'b0;
            sync_fill_q <= 2'h0;
            frame_ok_q  <= 1'b0;
        end else if (ce_i) begin
            sync_fill_q <= {sync_fill_q[0], 1'b1};
            if (cs_s2_q && sync_fill_q[1]) begin
                seen_high_q <= 1'b1;
            end
            if (cs_fall) begin
                frame_ok_q <= seen_high_q;
            end else if (cs_rise) begin
                frame_ok_q <= 1'b0;
            end
        end
    end

    // Read pointer follows every byte, taken or not, so nothing piles up
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_bin_q <= '0;
        end else if (ce_i) begin
            if (cs_s2_q) begin
                rd_bin_q <= '0;
            end else if (byte_new) begin
                rd_bin_q <= rd_bin_q + 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Write cycle timer

    sefe_status_s  status_q;
    logic [TW-1:0] wip_cnt_q;
    logic          wr_pending_q;
    logic          wip_done;

    assign wip_done = status_q.write_in_progress && (wip_cnt_q == '0);

    // write cycle keeps device out of standby
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            wip_cnt_q <= '0;
        end else if (ce_i) begin
            if (cs_rise && wr_pending_q) begin
                wip_cnt_q <= TW'(WRITE_CYCLES - 1);
            end else if (wip_cnt_q != '0) begin
                wip_cnt_q <= wip_cnt_q - 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Byte sequencer, status and array access

    sefe_state_e       state_q;
    logic [7:0]        opcode_q;
    logic [15:0]       addr_q;
    logic [15:0]       addr_full;
    logic              out_en_q;
    logic              id_locked_q;
    logic              rd_req_q;
    logic              rd_vld_q;
    logic              mem_we_q;
    logic [MEM_AW-1:0] mem_waddr_q;
    logic [7:0]        mem_wdata_q;
    logic [MEM_AW-1:0] mem_raddr_q;
    logic [7:0]        mem_rdata;
    logic              is_id;
    logic              is_read;
    logic              prot_hit;
    logic [MEM_AW-1:0] mem_idx;
    logic [15:0]       addr_wr_nxt;

    assign addr_full   = {addr_q[15:8], rx_byte_q};
    assign is_id       = (opcode_q == OP_RDID) || (opcode_q == OP_WRID);
    assign is_read     = (opcode_q == OP_READ) || (opcode_q == OP_RDID);
    // Writes wrap inside one page
    assign addr_wr_nxt = {addr_q[15:6], 6'(addr_q[5:0] + 6'h01)};

    always_comb begin
        if (is_id) begin
            mem_idx = MEM_AW'(ARRAY_WORDS) + MEM_AW'(addr_q[5:0]);
        end else begin
            mem_idx = {1'b0, addr_q[14:0]};
        end
    end

    // Protected region from the block-protect bits
    always_comb begin
        case ({status_q.prot_size_hi, status_q.prot_size_lo})
            2'b01:   prot_hit = addr_q[14:0] >= PROT_QUARTER_BASE;
            2'b10:   prot_hit = addr_q[14:0] >= PROT_HALF_BASE;
            2'b11:   prot_hit = 1'b1;
            default: prot_hit = 1'b0;
        endcase
        if (is_id) begin
            prot_hit = id_locked_q;
        end
    end

    // Sequencer; latch bits live here too so a frame reset spares them
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q       <= S_OPCODE;
            opcode_q      <= 8'h00;
            addr_q        <= 16'h0000;
            out_en_q      <= 1'b0;
            rd_req_q      <= 1'b0;
            mem_we_q      <= 1'b0;
            mem_waddr_q   <= '0;
            mem_wdata_q   <= 8'h00;
            mem_raddr_q   <= '0;
            wr_pending_q  <= 1'b0;
            id_locked_q   <= 1'b0;
            status_q      <= '{PROT_SIZE_RST[1], PROT_SIZE_RST[0], 1'b0, 1'b0};
        end else if (ce_i) begin
            rd_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            if (wip_done) begin
                status_q.write_in_progress <= 1'b0;
            end
            if (cs_s2_q) begin
                // deselect resets sequencer, keeps latch bits except the write enable latch after a write
                state_q  <= S_OPCODE;
                out_en_q <= 1'b0;
                if (cs_rise && wr_pending_q) begin
                    status_q.write_in_progress  <= 1'b1;
                    status_q.write_enable_latch <= 1'b0;
                end
                wr_pending_q <= 1'b0;
            end else if (byte_take) begin
                case (state_q)
                    S_OPCODE: begin
                        opcode_q <= rx_byte_q;
                        state_q  <= S_SKIP;
                        // Busy device answers only status reads
                        if (status_q.write_in_progress && rx_byte_q != OP_RDSR) begin
                            state_q <= S_SKIP;
                        end else if (rx_byte_q == OP_WREN) begin
                            status_q.write_enable_latch <= 1'b1;
                        end else if (rx_byte_q == OP_WRDI) begin
                            status_q.write_enable_latch <= 1'b0;
                        end else if (rx_byte_q == OP_RDSR) begin
                            state_q  <= S_STAT;
                            out_en_q <= 1'b1;
                        end else if (rx_byte_q == OP_WRSR) begin
                            state_q <= S_WRSR;
                        end else if (rx_byte_q == OP_READ || rx_byte_q == OP_WRITE) begin
                            state_q <= S_ADDR_HI;
                        end else if (HAS_ID_PAGE && (rx_byte_q == OP_RDID || rx_byte_q == OP_WRID)) begin
                            state_q <= S_ADDR_HI;
                        end
                    end
                    S_ADDR_HI: begin
                        addr_q[15:8] <= rx_byte_q;
                        state_q      <= S_ADDR_LO;
                    end
                    S_ADDR_LO: begin
                        addr_q[7:0] <= rx_byte_q;
                        state_q     <= S_DATA;
                        if (is_read) begin
                            mem_raddr_q <= is_id ? MEM_AW'(ARRAY_WORDS) + MEM_AW'(rx_byte_q[5:0])
                                                 : {1'b0, addr_full[14:0]};
                            rd_req_q    <= 1'b1;
                            out_en_q    <= 1'b1;
                            addr_q      <= addr_full + 16'h0001;
                        end
                    end
                    S_DATA: begin
                        if (is_read) begin
                            mem_raddr_q <= mem_idx;
                            rd_req_q    <= 1'b1;
                            addr_q      <= addr_q + 16'h0001;
                        end else begin
                            addr_q <= addr_wr_nxt;
                            if (status_q.write_enable_latch && !prot_hit) begin
                                wr_pending_q <= 1'b1;
                                // lock makes page read-only until reset
                                if (is_id && addr_q[LOCK_ADDR_BIT]) begin
                                    id_locked_q <= 1'b1;
                                end else begin
                                    mem_we_q    <= 1'b1;
                                    mem_waddr_q <= mem_idx;
                                    mem_wdata_q <= rx_byte_q;
                                end
                            end
                        end
                    end
                    S_WRSR: begin
                        state_q <= S_SKIP;
                        if (status_q.write_enable_latch) begin
                            wr_pending_q <= 1'b1;
                            // protect pin low freezes size bits
                            if (wp_s2_q) begin
                                status_q.prot_size_hi <= rx_byte_q[3];
                                status_q.prot_size_lo <= rx_byte_q[2];
                            end
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // Next transmit byte: status bytes repeat, array bytes follow the fetch
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            rd_vld_q  <= 1'b0;
            tx_byte_q <= 8'h00;
        end else if (ce_i) begin
            rd_vld_q <= rd_req_q;
            if (state_q == S_STAT) begin
                tx_byte_q <= {4'h0, status_q};
            end else if (rd_vld_q) begin
                tx_byte_q <= mem_rdata;
            end
        end
    end

    sefe_mem #(
        .DW    (8),
        .DEPTH (MEM_DEPTH),
        .AW    (MEM_AW)
    ) u_mem (
        .clk_i   (clk_sys_i),
        .en_i    (ce_i),
        .we_i    (mem_we_q),
        .waddr_i (mem_waddr_q),
        .wdata_i (mem_wdata_q),
        .raddr_i (mem_raddr_q),
        .rdata_o (mem_rdata)
    );

    //////////////////////////////////////////////////////////////////////////
    // Pin enable and power state outputs

    // Enable follows the synchronised pins, so it lags them by a few cycles
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            spi_miso_oe_n_o <= 1'b1;
            active_o        <= 1'b0;
            standby_o       <= 1'b1;
            paused_o        <= 1'b0;
            status_o        <= '0;
        end else if (ce_i) begin
            // output off when deselected or paused
            spi_miso_oe_n_o <= ~(out_en_q & frame_ok_q & ~cs_s2_q & hold_s2_q);
            active_o        <= ~cs_s2_q;
            standby_o       <= cs_s2_q & ~status_q.write_in_progress;
            paused_o        <= ~cs_s2_q & ~hold_s2_q;
            status_o        <= status_q;
        end
    end

endmodule

// ---- sefe_checker.sv ----
// Port-level assertions for the serial EEPROM front end
module sefe_checker (
    input wire logic            clk_sys_i,
    input wire logic            rst_n_i,
    input wire logic            spi_sck_i,
    input wire logic            spi_cs_n_i,
    input wire logic            spi_hold_n_i,
    input wire logic            spi_wp_n_i,
    input wire logic            spi_miso_o,
    input wire logic            spi_miso_oe_n_o,
    input wire logic            active_o,
    input wire logic            standby_o,
    input wire logic            paused_o,
    input wire sefe_pkg::sefe_status_s status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sefe_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    // Select and standby follow chip select within the sync lag
    a_active_sel: assert property (!spi_cs_n_i [*5] |-> active_o)
        else $error("not active while selected");
    a_active_desel: assert property (spi_cs_n_i [*5] |-> !active_o)
        else $error("active while deselected");
    a_desel_off: assert property (spi_cs_n_i [*5] |-> spi_miso_oe_n_o)
        else $error("output driven while deselected");
    a_standby_idle: assert property ((spi_cs_n_i && !status_o.write_in_progress) [*5] |-> standby_o)
        else $error("no standby while idle");
    a_no_standby_wr: assert property (status_o.write_in_progress [*3] |-> !standby_o)
        else $error("standby during write cycle");
    // Output only from a select that is several cycles old; guards a stuck enable
    a_oe_selected: assert property (!spi_miso_oe_n_o |-> !$past(spi_cs_n_i, 5))
        else $error("output driven without select");
    ////////////////////////////////////////////////////////////////////////
    // Serial output moves only with a falling serial clock
    a_miso_on_fall: assert property (!spi_cs_n_i && !$past(spi_cs_n_i) && $changed(spi_miso_o)
        |-> $fell(spi_sck_i))
        else $error("serial output moved off a falling edge");
    // Pause entered with the clock low
    a_pause_flag: assert property ((!spi_cs_n_i && !spi_hold_n_i && !spi_sck_i) [*5] |-> paused_o)
        else $error("pause not reported");
    a_pause_off: assert property ((!spi_hold_n_i && !spi_sck_i) [*5] |-> spi_miso_oe_n_o)
        else $error("output driven while paused");
    // Protect size is frozen once the synchronised protect input is low
    a_wp_freeze: assert property (!spi_wp_n_i [*4] |=> $stable({status_o.prot_size_hi, status_o.prot_size_lo}))
        else $error("protect size changed under write protect");
    c_read_out: cover property (!spi_miso_oe_n_o);
    c_paused: cover property (paused_o);
    c_writing: cover property (status_o.write_in_progress);
endmodule

bind sefe_top sefe_checker u_chk (.clk_sys_i, .rst_n_i, .spi_sck_i, .spi_cs_n_i, .spi_hold_n_i, .spi_wp_n_i,
    .spi_miso_o, .spi_miso_oe_n_o, .active_o, .standby_o, .paused_o, .status_o);

// ---- sefe_spi_master.sv ----
// Bus master model driving the serial port in mode 0 or 3
module sefe_spi_master (
    output logic      spi_sck_o,
    output logic      spi_cs_n_o,
    output logic      spi_mosi_o,
    output logic      spi_hold_n_o,
    output logic      spi_wp_n_o,
    input  wire logic spi_miso_i,
    input  wire logic spi_miso_oe_n_i
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam time HALF = 80ns;
    logic cpol;
    // Released line reads inverted so stale data never passes as a match
    wire miso_w = spi_miso_oe_n_i ? ~spi_miso_i : spi_miso_i;
    initial begin
        cpol = 1'b0;
        spi_sck_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        spi_hold_n_o = 1'b1;
        spi_wp_n_o = 1'b1;
    end
    // park clock, then select only this device
    task automatic start(input logic mode3);
        cpol = mode3;
        spi_sck_o <= mode3;
        #HALF spi_cs_n_o <= 1'b0;
        #HALF;
    endtask
    task automatic stop();
        spi_sck_o <= cpol;
        #HALF spi_cs_n_o <= 1'b1;
        #(2 * HALF);
    endtask
    // MSB first, data launched on fall, taken at rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_sck_o <= 1'b0;
            spi_mosi_o <= tx[i];
            #HALF rx[i] = miso_w;
            spi_sck_o <= 1'b1;
            #HALF;
        end
    endtask
    // pause with clock low, select held unless drop raises it; junk clocks meanwhile
    task automatic pause(input logic drop);
        spi_sck_o <= 1'b0;
        #HALF spi_hold_n_o <= 1'b0;
        repeat (3) begin
            #HALF spi_sck_o <= 1'b1;
            spi_mosi_o <= ~spi_mosi_o;
            #HALF spi_sck_o <= 1'b0;
        end
        if (drop)
            spi_cs_n_o <= 1'b1;
        #HALF spi_hold_n_o <= 1'b1;
        #HALF;
    endtask
    // protect level changes only between frames
    task automatic set_wp(input logic v);
        spi_wp_n_o <= v;
    endtask
endmodule

// ---- testbench.sv ----
// Self-checking bench for the serial EEPROM front end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sefe_pkg::*;
    logic         clk_sys_i = 1'b0;
    logic         rst_n_i = 1'b0;
    logic         ce = 1'b1;
    logic         sck, cs_n, mosi, hold_n, wp_n, miso, oe_n, active, standby, paused;
    sefe_status_s status;
    int           n_fail = 0;
    int           samples_checked = 0;
    logic [7:0]   rx[$];
    logic [7:0]   b;
    always #5 clk_sys_i = ~clk_sys_i;
    // Short write timer keeps the run brief
    sefe_top #(.WRITE_CYCLES(60), .HAS_ID_PAGE(1'b1)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_hold_n_i(hold_n), .spi_wp_n_i(wp_n),
        .spi_miso_o(miso), .spi_miso_oe_n_o(oe_n), .active_o(active), .standby_o(standby), .paused_o(paused),
        .status_o(status));
    sefe_spi_master mst (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi), .spi_hold_n_o(hold_n),
        .spi_wp_n_o(wp_n), .spi_miso_i(miso), .spi_miso_oe_n_i(oe_n));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic frame(input logic [7:0] tx[$], input logic mode3);
        logic [7:0] v;
        rx = {};
        mst.start(mode3);
        foreach (tx[i]) begin
            mst.xfer(tx[i], v);
            rx.push_back(v);
        end
        mst.stop();
    endtask
    task automatic test_done();
        $display("checked %0d values, %0d wrong", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Bounded wait for the internal write cycle to end
    task automatic wait_write();
        int n;
        for (n = 0; n < 300 && status.write_in_progress !== 1'b0; n++)
            @(posedge clk_sys_i);
        if (n == 300) begin
            n_fail++;
            $display("wrong value at %0t: write cycle never ended", $time);
            test_done();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_pause_deselect();
        frame('{OP_WREN}, 1'b0);
        mst.start(1'b0);
        mst.xfer(OP_READ, b);
        check(8'(active), 8'h01, "active in frame");
        mst.pause(1'b1);
        mst.stop();
        check(8'(oe_n), 8'h01, "output off");
        check(8'({active, standby}), 8'h01, "standby");
        check(8'(status.write_enable_latch), 8'h01, "latch kept");
        $display("test pause_deselect done");
    endtask
    task automatic test_write_read();
        frame('{OP_WRITE, 8'h01, 8'h23, 8'h5a, 8'hc3}, 1'b0);
        check(8'({status.write_in_progress, standby}), 8'h02, "writing");
        wait_write();
        check(8'(status.write_enable_latch), 8'h00, "latch cleared");
        mst.start(1'b0);
        mst.xfer(OP_READ, b);
        mst.xfer(8'h01, b);
        mst.xfer(8'h23, b);
        mst.xfer(8'h00, b);
        check(b, 8'h5a, "first byte");
        mst.pause(1'b0);
        mst.xfer(8'h00, b);
        check(b, 8'hc3, "byte after pause");
        mst.stop();
        $display("test write_read done");
    endtask
    task automatic test_mode3();
        frame('{OP_READ, 8'h01, 8'h24, 8'h00}, 1'b1);
        check(rx[3], 8'hc3, "mode 3 read");
        frame('{OP_WREN}, 1'b1);
        frame('{OP_RDSR, 8'h00}, 1'b1);
        check(rx[1], 8'h02, "status latch set");
        frame('{OP_WRDI}, 1'b1);
        frame('{OP_RDSR, 8'h00}, 1'b1);
        check(rx[1], 8'h00, "status latch clear");
        $display("test mode3 done");
    endtask
    task automatic test_protect();
        mst.set_wp(1'b0);
        frame('{OP_WREN}, 1'b0);
        frame('{OP_WRSR, 8'h0c}, 1'b0);
        wait_write();
        check(8'({status.prot_size_hi, status.prot_size_lo}), 8'h00, "size frozen");
        mst.set_wp(1'b1);
        frame('{OP_WREN}, 1'b0);
        frame('{OP_WRSR, 8'h0c}, 1'b0);
        wait_write();
        check(8'({status.prot_size_hi, status.prot_size_lo}), 8'h03, "size set");
        $display("test protect done");
    endtask
    // Write cycle timer must freeze while the enable is low
    task automatic test_id_page();
        frame('{OP_WREN}, 1'b0);
        frame('{OP_WRID, 8'h00, 8'h05, 8'ha7}, 1'b0);
        @(posedge clk_sys_i) ce <= 1'b0;
        repeat (100) @(posedge clk_sys_i);
        check(8'({status.write_in_progress, standby}), 8'h02, "timer frozen");
        ce <= 1'b1;
        wait_write();
        frame('{OP_RDID, 8'h00, 8'h05, 8'h00}, 1'b0);
        check(rx[3], 8'ha7, "id page byte");
        $display("test id_page done");
    endtask
    // Select already low across a mid-run reset: that frame must be ignored
    task automatic test_power_up();
        rst_n_i <= 1'b0;
        mst.start(1'b0);
        @(posedge clk_sys_i) rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        mst.xfer(OP_WREN, b);
        mst.stop();
        check(8'(status.write_enable_latch), 8'h00, "frame without prior high");
        frame('{OP_WREN}, 1'b0);
        check(8'(status.write_enable_latch), 8'h01, "frame after high");
        $display("test power_up done");
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #3;
        test_pause_deselect();
        test_write_read();
        test_mode3();
        test_protect();
        test_id_page();
        test_power_up();
        test_done();
    end
endmodule
